//--- core/gpio_function_mux.sv
// General purpose pin function multiplexer, top level
// What this block does
// - Each pin has 8-bit select, reset zero
// - Select 0x10: pin is external reference-loss input
// - Select 0x20: pin ORed into accumulator clear
// - Selects 0x44-0x47: pin ORed into clock stops
// - Selects 0x70/0x72: pin ORed into output enables
// - Select 0x80: pin driven high on interrupt
// - Interrupt output flags device status changes
// - Select 0x88: pin shows reference inactivity
// - Select 0x89: pin shows period check failure
// - Select 0x8A: pin shows coarse frequency failure
// - Select 0x8B: pin shows soak timer indicator
// - Select 0x8C: masked OR of four failures
// - Select 0xA8: high in normal locking mode
// - Select 0xA9: high in holdover mode
// - Select 0xAD: high when beyond range limit
// - Select 0xAF: lock level 0 indication
// - Select 0xB0: lock level 1 indication
// - Select 0xB1: lock level 2 indication
// - Select 0xB2: lock level 3 indication
`timescale 1ns/1ps
module gpio_function_mux
    import gpio_fn_pkg::*;
(
    input  wire logic                sys_clk_in,
    input  wire logic                rstn_in,
    // Select register write and read access
    input  wire logic                cfg_wr_en_in,
    input  wire logic [2:0]          cfg_pin_in,
    input  wire logic [SEL_W-1:0]    cfg_data_in,
    output logic      [SEL_W-1:0]    cfg_rd_data_out,
    // Pins
    input  wire logic [NUM_PINS-1:0] gpio_in,
    output logic      [NUM_PINS-1:0] gpio_out,
    output logic      [NUM_PINS-1:0] gpio_oe_n_out,
    // Register bits that pins may be ORed into, plus the failure mask
    input  wire logic                tie_clr_bit_in,
    input  wire logic [1:0]          stop_a_bits_in,
    input  wire logic [1:0]          stop_b_bits_in,
    input  wire logic                en_a_bit_in,
    input  wire logic                en_b_bit_in,
    input  wire logic [3:0]          fail_mask_in,
    // Status sources
    input  wire logic                irq_in,
    input  wire logic                no_activity_in,
    input  wire logic                period_check_in,
    input  wire logic                coarse_freq_check_in,
    input  wire logic                qualify_soak_timer_in,
    input  wire logic                holdover_in,
    input  wire logic                freerun_in,
    input  wire logic                out_of_range_in,
    input  wire logic [3:0]          lock_level_in,
    // Effective controls
    output logic                     signal_loss_flag_out,
    output logic                     phase_error_accum_clr_out,
    output logic      [1:0]          stop_a_out,
    output logic      [1:0]          stop_b_out,
    output logic                     fast_cmos_out_a_en_out,
    output logic                     fast_cmos_out_b_en_out
);
    logic [NUM_PINS-1:0][CT_W-1:0]  ctrl_all;
    logic [NUM_PINS-1:0][SEL_W-1:0] sel_all;
    logic [NUM_PINS-1:0]            drv_all;
    logic [NUM_PINS-1:0]            val_all;
    logic [CT_W-1:0]                ctrl_or;
    logic [ST_W-1:0]                stat_c;

    // Pin slices, one per general purpose pin
    pin_fn_if pif[NUM_PINS] ();
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            gpio_pin_slice u_slice (
                .sys_clk_in (sys_clk_in),
                .rstn_in    (rstn_in),
                .wr_en_in   (cfg_wr_en_in && (cfg_pin_in == 3'(gi))),
                .wr_data_in (cfg_data_in),
                .pin_in     (gpio_in[gi]),
                .fn         (pif[gi])
            );
            assign pif[gi].stat = stat_c;
            assign ctrl_all[gi] = pif[gi].ctrl;
            assign sel_all[gi]  = pif[gi].sel;
            assign drv_all[gi]  = pif[gi].drv;
            assign val_all[gi]  = pif[gi].val;
        end
    endgenerate

    // Merge control contributions from every pin
    always_comb begin
        ctrl_or = '0;
        for (int i = 0; i < NUM_PINS; i++) begin
            ctrl_or = ctrl_or | ctrl_all[i];
        end
    end

    // Status vector; normal means neither holdover nor freerun
    always_comb begin
        stat_c            = '0;
        stat_c[ST_IRQ]    = irq_in;
        stat_c[ST_NO_ACT] = no_activity_in;
        stat_c[ST_PER]    = period_check_in;
        stat_c[ST_CFQ]    = coarse_freq_check_in;
        stat_c[ST_SOAK]   = qualify_soak_timer_in;
        // A mask bit of one lets that source through
        stat_c[ST_FAIL]   = (ctrl_or[CT_LOS] & fail_mask_in[MK_LOS])
                          | (period_check_in & fail_mask_in[MK_PER])
                          | (coarse_freq_check_in & fail_mask_in[MK_CFQ])
                          | (qualify_soak_timer_in & fail_mask_in[MK_SOAK]);
        stat_c[ST_NORMAL] = ~holdover_in & ~freerun_in;
        stat_c[ST_HOLD]   = holdover_in;
        stat_c[ST_RANGE]  = out_of_range_in;
        stat_c[ST_LOCK0 +: 4] = lock_level_in;
    end

    // Output register next values
    logic [NUM_PINS-1:0] gpio_d;
    logic [NUM_PINS-1:0] oe_n_d;
    logic                los_d;
    logic                tie_d;
    logic [1:0]          stop_a_d;
    logic [1:0]          stop_b_d;
    logic                en_a_d;
    logic                en_b_d;
    logic [SEL_W-1:0]    rd_d;

    always_comb begin
        gpio_d   = val_all;
        oe_n_d   = ~drv_all;
        los_d    = ctrl_or[CT_LOS];
        tie_d    = tie_clr_bit_in | ctrl_or[CT_TIE];
        stop_a_d = stop_a_bits_in | {ctrl_or[CT_A1], ctrl_or[CT_A0]};
        stop_b_d = stop_b_bits_in | {ctrl_or[CT_B1], ctrl_or[CT_B0]};
        en_a_d   = en_a_bit_in | ctrl_or[CT_EN_A];
        en_b_d   = en_b_bit_in | ctrl_or[CT_EN_B];
        rd_d     = '0;
        // Pin numbers past the last pin read as zero
        if (cfg_pin_in < 3'(NUM_PINS)) begin
            rd_d = sel_all[cfg_pin_in];
        end
    end

    // All outputs come from flops; pins stay undriven in reset
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            gpio_out                  <= '0;
            gpio_oe_n_out             <= '1;
            signal_loss_flag_out      <= 1'b0;
            phase_error_accum_clr_out <= 1'b0;
            stop_a_out                <= '0;
            stop_b_out                <= '0;
            fast_cmos_out_a_en_out    <= 1'b0;
            fast_cmos_out_b_en_out    <= 1'b0;
            cfg_rd_data_out           <= '0;
        end else begin
            gpio_out                  <= gpio_d;
            gpio_oe_n_out             <= oe_n_d;
            signal_loss_flag_out      <= los_d;
            phase_error_accum_clr_out <= tie_d;
            stop_a_out                <= stop_a_d;
            stop_b_out                <= stop_b_d;
            fast_cmos_out_a_en_out    <= en_a_d;
            fast_cmos_out_b_en_out    <= en_b_d;
            cfg_rd_data_out           <= rd_d;
        end
    end

    // Slices are identical; control checks watch pin 3 and status checks pin 4,
    // which carry real traffic, so no antecedent sits idle
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);

    // Select register and readback
    a_sel_write_store: assert property (
        (cfg_wr_en_in && cfg_pin_in == 3'd0) |=> (sel_all[0] == $past(cfg_data_in)))
        else $error("select write not stored");

    a_sel_readback: assert property (
        (cfg_pin_in == 3'd3) |=> (cfg_rd_data_out == $past(sel_all[3])))
        else $error("select readback wrong");

    a_rd_absent_pin: assert property (
        (cfg_pin_in == 3'd7) |=> (cfg_rd_data_out == 8'h00))
        else $error("absent pin read nonzero");

    a_default_undriven: assert property (
        (sel_all[4] == SEL_NONE) |=> gpio_oe_n_out[4])
        else $error("default pin was driven");

    // Control group: pin level ORed inward
    a_los_input_path: assert property (
        (sel_all[3] == SEL_LOS && gpio_in[3]) |=> signal_loss_flag_out)
        else $error("loss input not forwarded");

    a_los_pin_input: assert property (
        (sel_all[3] == SEL_LOS) |=> gpio_oe_n_out[3])
        else $error("loss input pin was driven");

    a_tie_bit_or: assert property (
        (tie_clr_bit_in || (sel_all[3] == SEL_TIE_CLR && gpio_in[3])) |=> phase_error_accum_clr_out)
        else $error("accumulator clear not ORed");

    a_tie_idle: assert property (
        (!tie_clr_bit_in && !ctrl_or[CT_TIE]) |=> !phase_error_accum_clr_out)
        else $error("accumulator clear set spuriously");

    a_stop_a1_or: assert property (
        (sel_all[3] == SEL_STOP_A1 && gpio_in[3]) |=> stop_a_out[1])
        else $error("divider A stop bit1 not ORed");

    a_stop_a0_or: assert property (
        (sel_all[3] == SEL_STOP_A0 && gpio_in[3]) |=> stop_a_out[0])
        else $error("divider A stop bit0 not ORed");

    a_stop_b1_or: assert property (
        (sel_all[3] == SEL_STOP_B1 && gpio_in[3]) |=> stop_b_out[1])
        else $error("divider B stop bit1 not ORed");

    a_stop_b0_or: assert property (
        (sel_all[3] == SEL_STOP_B0 && gpio_in[3]) |=> stop_b_out[0])
        else $error("divider B stop bit0 not ORed");

    a_stop_reg_kept: assert property (
        1'b1 |=> ((stop_a_out & $past(stop_a_bits_in)) == $past(stop_a_bits_in)
               && (stop_b_out & $past(stop_b_bits_in)) == $past(stop_b_bits_in)))
        else $error("stop register bit lost");

    a_enable_a_or: assert property (
        (sel_all[3] == SEL_EN_A && gpio_in[3]) |=> fast_cmos_out_a_en_out)
        else $error("first output enable not ORed");

    a_enable_b_or: assert property (
        (sel_all[3] == SEL_EN_B && gpio_in[3]) |=> fast_cmos_out_b_en_out)
        else $error("second output enable not ORed");

    a_enable_bits_kept: assert property (
        (en_a_bit_in && en_b_bit_in) |=> (fast_cmos_out_a_en_out && fast_cmos_out_b_en_out))
        else $error("enable register bit lost");

    // Status group: source level driven out one edge later
    a_irq_pin_drive: assert property (
        (sel_all[4] == SEL_IRQ) |=> (!gpio_oe_n_out[4] && gpio_out[4] == $past(irq_in)))
        else $error("interrupt not shown on pin");

    a_irq_pin_rise: assert property (
        (sel_all[4] == SEL_IRQ && $rose(irq_in)) |=> $rose(gpio_out[4]))
        else $error("interrupt change not flagged");

    a_no_act_pin: assert property (
        (sel_all[4] == SEL_NO_ACT) |=> (!gpio_oe_n_out[4] && gpio_out[4] == $past(no_activity_in)))
        else $error("inactivity not shown on pin");

    a_period_pin: assert property (
        (sel_all[4] == SEL_PERIOD) |=> (!gpio_oe_n_out[4] && gpio_out[4] == $past(period_check_in)))
        else $error("period check not shown on pin");

    a_coarse_pin: assert property (
        (sel_all[4] == SEL_COARSE) |=> (!gpio_oe_n_out[4] && gpio_out[4] == $past(coarse_freq_check_in)))
        else $error("coarse check not shown on pin");

    a_soak_pin: assert property (
        (sel_all[4] == SEL_SOAK) |=> (!gpio_oe_n_out[4] && gpio_out[4] == $past(qualify_soak_timer_in)))
        else $error("soak timer not shown on pin");

    a_fail_mask_gate: assert property (
        (sel_all[4] == SEL_REF_FAIL && period_check_in && !fail_mask_in[MK_PER]
         && !(ctrl_or[CT_LOS] && fail_mask_in[MK_LOS]) && !(coarse_freq_check_in && fail_mask_in[MK_CFQ])
         && !(qualify_soak_timer_in && fail_mask_in[MK_SOAK])) |=> !gpio_out[4])
        else $error("masked failure leaked to pin");

    a_fail_unmasked: assert property (
        (sel_all[4] == SEL_REF_FAIL && period_check_in && fail_mask_in[MK_PER]) |=> gpio_out[4])
        else $error("unmasked failure not shown");

    a_normal_mode_pin: assert property (
        (sel_all[4] == SEL_NORMAL) |=> (gpio_out[4] == $past(!holdover_in && !freerun_in)))
        else $error("normal mode indication wrong");

    a_hold_pin: assert property (
        (sel_all[4] == SEL_HOLD) |=> (!gpio_oe_n_out[4] && gpio_out[4] == $past(holdover_in)))
        else $error("holdover not shown on pin");

    a_range_pin: assert property (
        (sel_all[4] == SEL_RANGE) |=> (!gpio_oe_n_out[4] && gpio_out[4] == $past(out_of_range_in)))
        else $error("range flag not shown on pin");

    a_lock0_pin: assert property (
        (sel_all[4] == SEL_LOCK0) |=> (gpio_out[4] == $past(lock_level_in[0])))
        else $error("lock level 0 not shown");

    a_lock1_pin: assert property (
        (sel_all[4] == SEL_LOCK1) |=> (gpio_out[4] == $past(lock_level_in[1])))
        else $error("lock level 1 not shown");

    a_lock2_pin: assert property (
        (sel_all[4] == SEL_LOCK2) |=> (gpio_out[4] == $past(lock_level_in[2])))
        else $error("lock level 2 not shown");

    a_lock3_pin: assert property (
        (sel_all[4] == SEL_LOCK3) |=> (gpio_out[4] == $past(lock_level_in[3])))
        else $error("lock level 3 not shown");

    // Unassigned codes must act exactly like the default
    a_unassigned_idle: assert property (
        (sel_all[3] inside {8'h01, 8'h11, 8'h71, 8'h8d, 8'hff})
        |=> (gpio_oe_n_out[3] && signal_loss_flag_out == $past(ctrl_or[CT_LOS])))
        else $error("unassigned select had an effect");
endmodule : gpio_function_mux

//--- core/gpio_fn_pkg.sv
// Constants shared by the general purpose pin function multiplexer
package gpio_fn_pkg;
    localparam int        NUM_PINS      = 7;
    localparam int        SEL_W         = 8;
    localparam logic [7:0] SEL_RESET    = 8'h00;
    // Function select codes, control group
    localparam logic [7:0] SEL_NONE     = 8'h00;
    localparam logic [7:0] SEL_LOS      = 8'h10;
    localparam logic [7:0] SEL_TIE_CLR  = 8'h20;
    localparam logic [7:0] SEL_STOP_A1  = 8'h44;
    localparam logic [7:0] SEL_STOP_A0  = 8'h45;
    localparam logic [7:0] SEL_STOP_B1  = 8'h46;
    localparam logic [7:0] SEL_STOP_B0  = 8'h47;
    localparam logic [7:0] SEL_EN_A     = 8'h70;
    localparam logic [7:0] SEL_EN_B     = 8'h72;
    // Function select codes, status group
    localparam logic [7:0] SEL_IRQ      = 8'h80;
    localparam logic [7:0] SEL_NO_ACT   = 8'h88;
    localparam logic [7:0] SEL_PERIOD   = 8'h89;
    localparam logic [7:0] SEL_COARSE   = 8'h8a;
    localparam logic [7:0] SEL_SOAK     = 8'h8b;
    localparam logic [7:0] SEL_REF_FAIL = 8'h8c;
    localparam logic [7:0] SEL_NORMAL   = 8'ha8;
    localparam logic [7:0] SEL_HOLD     = 8'ha9;
    localparam logic [7:0] SEL_RANGE    = 8'had;
    localparam logic [7:0] SEL_LOCK0    = 8'haf;
    localparam logic [7:0] SEL_LOCK1    = 8'hb0;
    localparam logic [7:0] SEL_LOCK2    = 8'hb1;
    localparam logic [7:0] SEL_LOCK3    = 8'hb2;
    // Control vector bit positions
    localparam int CT_W      = 8;
    localparam int CT_LOS    = 0;
    localparam int CT_TIE    = 1;
    localparam int CT_A1     = 2;
    localparam int CT_A0     = 3;
    localparam int CT_B1     = 4;
    localparam int CT_B0     = 5;
    localparam int CT_EN_A   = 6;
    localparam int CT_EN_B   = 7;
    // Status vector bit positions
    localparam int ST_W      = 13;
    localparam int ST_IRQ    = 0;
    localparam int ST_NO_ACT = 1;
    localparam int ST_PER    = 2;
    localparam int ST_CFQ    = 3;
    localparam int ST_SOAK   = 4;
    localparam int ST_FAIL   = 5;
    localparam int ST_NORMAL = 6;
    localparam int ST_HOLD   = 7;
    localparam int ST_RANGE  = 8;
    localparam int ST_LOCK0  = 9;
    // Failure mask bit positions
    localparam int MK_LOS    = 0;
    localparam int MK_PER    = 1;
    localparam int MK_CFQ    = 2;
    localparam int MK_SOAK   = 3;
endpackage : gpio_fn_pkg

//--- core/pin_fn_if.sv
// Per-pin link between the multiplexer top and one pin slice
`timescale 1ns/1ps
interface pin_fn_if;
    import gpio_fn_pkg::*;
    logic [SEL_W-1:0] sel;
    logic [ST_W-1:0]  stat;
    logic [CT_W-1:0]  ctrl;
    logic             drv;
    logic             val;
    modport slice (input stat, output sel, output ctrl, output drv, output val);
    modport top   (output stat, input sel, input ctrl, input drv, input val);
endinterface : pin_fn_if

//--- core/gpio_pin_slice.sv
// One pin: function select register and its decode
`timescale 1ns/1ps
module gpio_pin_slice
    import gpio_fn_pkg::*;
(
    input  wire logic             sys_clk_in,
    input  wire logic             rstn_in,
    input  wire logic             wr_en_in,
    input  wire logic [SEL_W-1:0] wr_data_in,
    input  wire logic             pin_in,
    pin_fn_if.slice               fn
);
    logic [SEL_W-1:0] sel_q;
    logic [SEL_W-1:0] sel_d;

    // Select register next value
    always_comb begin
        sel_d = sel_q;
        if (wr_en_in) begin
            sel_d = wr_data_in;
        end
    end

    // Select register, plain input after reset
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sel_q <= SEL_RESET;
        end else begin
            sel_q <= sel_d;
        end
    end

    assign fn.sel = sel_q;

    // Decode: control codes feed the pin level inward, status codes drive it out
    always_comb begin
        fn.ctrl = '0;
        fn.drv  = 1'b0;
        fn.val  = 1'b0;
        case (sel_q)
            SEL_LOS:      fn.ctrl[CT_LOS]  = pin_in;
            SEL_TIE_CLR:  fn.ctrl[CT_TIE]  = pin_in;
            SEL_STOP_A1:  fn.ctrl[CT_A1]   = pin_in;
            SEL_STOP_A0:  fn.ctrl[CT_A0]   = pin_in;
            SEL_STOP_B1:  fn.ctrl[CT_B1]   = pin_in;
            SEL_STOP_B0:  fn.ctrl[CT_B0]   = pin_in;
            SEL_EN_A:     fn.ctrl[CT_EN_A] = pin_in;
            SEL_EN_B:     fn.ctrl[CT_EN_B] = pin_in;
            SEL_IRQ:      begin fn.drv = 1'b1; fn.val = fn.stat[ST_IRQ];    end
            SEL_NO_ACT:   begin fn.drv = 1'b1; fn.val = fn.stat[ST_NO_ACT]; end
            SEL_PERIOD:   begin fn.drv = 1'b1; fn.val = fn.stat[ST_PER];    end
            SEL_COARSE:   begin fn.drv = 1'b1; fn.val = fn.stat[ST_CFQ];    end
            SEL_SOAK:     begin fn.drv = 1'b1; fn.val = fn.stat[ST_SOAK];   end
            SEL_REF_FAIL: begin fn.drv = 1'b1; fn.val = fn.stat[ST_FAIL];   end
            SEL_NORMAL:   begin fn.drv = 1'b1; fn.val = fn.stat[ST_NORMAL]; end
            SEL_HOLD:     begin fn.drv = 1'b1; fn.val = fn.stat[ST_HOLD];   end
            SEL_RANGE:    begin fn.drv = 1'b1; fn.val = fn.stat[ST_RANGE];  end
            SEL_LOCK0:    begin fn.drv = 1'b1; fn.val = fn.stat[ST_LOCK0];   end
            SEL_LOCK1:    begin fn.drv = 1'b1; fn.val = fn.stat[ST_LOCK0+1]; end
            SEL_LOCK2:    begin fn.drv = 1'b1; fn.val = fn.stat[ST_LOCK0+2]; end
            SEL_LOCK3:    begin fn.drv = 1'b1; fn.val = fn.stat[ST_LOCK0+3]; end
            // Unassigned codes behave as the default input
            default:      fn.drv = 1'b0;
        endcase
    end
endmodule : gpio_pin_slice

//--- testbench/pin_board_model.sv
// Board-side model of the pins: strap levels after reset, then plain drivers
`timescale 1ns/1ps
module pin_board_model
    import gpio_fn_pkg::*;
#(
    parameter int STRAP_CYC = 20
)(
    input  wire logic                sys_clk_in,
    input  wire logic                rstn_in,
    input  wire logic [NUM_PINS-1:0] strap_in,
    input  wire logic [NUM_PINS-1:0] level_in,
    input  wire logic [NUM_PINS-1:0] dev_out_in,
    input  wire logic [NUM_PINS-1:0] dev_oe_n_in,
    output logic      [NUM_PINS-1:0] gpio_out,
    output logic                     ready_out
);
    int hold_q;
    // Hold time is scaled down so the run stays short
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            hold_q <= 0;
        end else if (hold_q < STRAP_CYC) begin
            hold_q <= hold_q + 1;
        end
    end
    assign ready_out = (hold_q >= STRAP_CYC);
    // Device wins where it drives, so the board never fights an output
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            if (!dev_oe_n_in[i]) begin
                gpio_out[i] = dev_out_in[i];
            end else begin
                gpio_out[i] = ready_out ? level_in[i] : strap_in[i];
            end
        end
    end
endmodule : pin_board_model

//--- testbench/gpio_function_mux_bench.sv
// Self-checking bench for the pin function multiplexer
`timescale 1ns/1ps
module gpio_function_mux_bench;
    import gpio_fn_pkg::*;
    logic                clk = 0, rstn = 0, wr = 0, lvl3 = 0, clr_bit = 0, en_a = 0, en_b = 0;
    logic [2:0]          pin = 0;
    logic [7:0]          data = 0, rd;
    logic [1:0]          sa = 0, sb = 0, st_a, st_b;
    logic [3:0]          mask = 4'hf;
    logic [12:0]         src = 0;
    logic [NUM_PINS-1:0] g_in, g_out, oe_n;
    logic                loss_flag, clr, ea, eb, ready;
    int                  bad_count = 0, checked = 0;
    wire  [7:0]          ctl = {loss_flag, clr, st_a, st_b, ea, eb};

    gpio_function_mux i_dut (.sys_clk_in(clk), .rstn_in(rstn), .cfg_wr_en_in(wr), .cfg_pin_in(pin),
        .cfg_data_in(data), .cfg_rd_data_out(rd), .gpio_in(g_in), .gpio_out(g_out), .gpio_oe_n_out(oe_n),
        .tie_clr_bit_in(clr_bit), .stop_a_bits_in(sa), .stop_b_bits_in(sb), .en_a_bit_in(en_a),
        .en_b_bit_in(en_b), .fail_mask_in(mask), .irq_in(src[0]), .no_activity_in(src[1]),
        .period_check_in(src[2]), .coarse_freq_check_in(src[3]), .qualify_soak_timer_in(src[4]),
        .holdover_in(src[5]), .freerun_in(src[6]), .out_of_range_in(src[7]), .lock_level_in(src[11:8]),
        .signal_loss_flag_out(loss_flag), .phase_error_accum_clr_out(clr), .stop_a_out(st_a),
        .stop_b_out(st_b), .fast_cmos_out_a_en_out(ea), .fast_cmos_out_b_en_out(eb));
    // Pin 3 carries control stimulus, pin 5 the external loss input
    pin_board_model #(.STRAP_CYC(20)) i_board (.sys_clk_in(clk), .rstn_in(rstn), .strap_in(7'h1b),
        .level_in({1'b0, src[12], 1'b0, lvl3, 3'h0}), .dev_out_in(g_out), .dev_oe_n_in(oe_n),
        .gpio_out(g_in), .ready_out(ready));

    initial forever #5 clk = ~clk;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Three edges cover the two-stage path from any input to the pins
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask : settle
    task automatic wr_sel(input logic [2:0] p, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        pin <= p;
        data <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_sel
    task automatic rd_sel(input logic [2:0] p, input logic [7:0] exp);
        @(posedge clk);
        pin <= p;
        settle();
        check(rd, exp);
    endtask : rd_sel
    task automatic wait_ready;
        for (int i = 0; i < 100 && !ready; i++) @(posedge clk);
        check({7'h0, ready}, 8'h01);
    endtask : wait_ready
    // Expected pin level of a status select, built from the source vector
    function automatic logic exp_st(input logic [7:0] c, input logic [12:0] s, input logic [3:0] m);
        case (c)
            8'h80: return s[0];
            8'h88: return s[1];
            8'h89: return s[2];
            8'h8a: return s[3];
            8'h8b: return s[4];
            8'h8c: return (s[12] & m[0]) | (s[2] & m[1]) | (s[3] & m[2]) | (s[4] & m[3]);
            8'ha8: return !(s[5] | s[6]);
            8'ha9: return s[5];
            8'had: return s[7];
            8'haf: return s[8];
            8'hb0: return s[9];
            8'hb1: return s[10];
            8'hb2: return s[11];
            default: return 1'b0;
        endcase
    endfunction : exp_st

    task automatic t_reset;
        for (int p = 0; p < 8; p++) rd_sel(p[2:0], 8'h00);
        check({1'b0, oe_n}, 8'h7f);
        check(ctl, 8'h00);
    endtask : t_reset
    task automatic t_ctrl;
        logic [7:0] codes [8] = '{8'h10, 8'h20, 8'h44, 8'h45, 8'h46, 8'h47, 8'h70, 8'h72};
        for (int k = 0; k < 8; k++) begin
            wr_sel(3'd3, codes[k]);
            lvl3 <= 1'b1;
            settle();
            check(ctl, 8'h80 >> k);
            check({7'h0, oe_n[3]}, 8'h01);
            @(posedge clk);
            lvl3 <= 1'b0;
            settle();
            check(ctl, 8'h00);
        end
        @(posedge clk);
        {clr_bit, sa, sb, en_a, en_b} <= 7'h7f;
        settle();
        check(ctl, 8'h7f);
        @(posedge clk);
        {clr_bit, sa, sb, en_a, en_b} <= 7'h00;
    endtask : t_ctrl
    // Unused codes are stored but must neither drive the pin nor feed any control
    task automatic t_unused;
        logic [7:0] codes [5] = '{8'h01, 8'h11, 8'h71, 8'h8d, 8'hff};
        @(posedge clk);
        lvl3 <= 1'b1;
        src <= 13'h0fff;
        for (int k = 0; k < 5; k++) begin
            wr_sel(3'd3, codes[k]);
            settle();
            check(ctl, 8'h00);
            check({7'h0, oe_n[3]}, 8'h01);
            rd_sel(3'd3, codes[k]);
        end
        wr_sel(3'd7, 8'h80);
        rd_sel(3'd7, 8'h00);
        check({1'b0, oe_n}, 8'h7f);
        @(posedge clk);
        lvl3 <= 1'b0;
        src <= 13'h0;
    endtask : t_unused
    task automatic t_status(input logic [3:0] m);
        logic [7:0] codes [13] = '{8'h80, 8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'ha8, 8'ha9, 8'had,
                                   8'haf, 8'hb0, 8'hb1, 8'hb2};
        logic [12:0] s;
        wr_sel(3'd5, 8'h10);
        mask <= m;
        for (int k = 0; k < 13; k++) begin
            wr_sel(3'd4, codes[k]);
            for (int j = 0; j < 14; j++) begin
                s = (j == 13) ? 13'h0 : 13'h1 << j;
                @(posedge clk);
                src <= s;
                settle();
                check({7'h0, oe_n[4]}, 8'h00);
                check({7'h0, g_out[4]}, {7'h0, exp_st(codes[k], s, m)});
            end
        end
    endtask : t_status
    // Write latency, back-to-back writes, then a reset in mid-run
    task automatic t_walk;
        @(posedge clk);
        src <= 13'h1;
        wr_sel(3'd0, 8'h80);
        #1;
        check({7'h0, oe_n[0]}, 8'h01);
        repeat (2) @(posedge clk);
        #1;
        check({6'h0, oe_n[0], g_out[0]}, 8'h01);
        @(posedge clk);
        wr <= 1'b1;
        pin <= 3'd1;
        data <= 8'hb2;
        @(posedge clk);
        pin <= 3'd2;
        data <= 8'ha9;
        @(posedge clk);
        wr <= 1'b0;
        rd_sel(3'd1, 8'hb2);
        rd_sel(3'd2, 8'ha9);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        wait_ready();
        rd_sel(3'd0, 8'h00);
        check({1'b0, oe_n}, 8'h7f);
    endtask : t_walk

    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        wait_ready();
        t_reset();
        t_ctrl();
        t_unused();
        t_status(4'hf);
        t_status(4'h5);
        t_walk();
        finish_test();
    end
    // The tests need about 1750 cycles; this limit leaves ample margin
    initial begin
        #500000;
        bad_count++;
        finish_test();
    end
endmodule : gpio_function_mux_bench
